// >>> logic/pio_consts.svh
// Constants for the programmable I/O cell bank: offsets, field positions, resets, timing.
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH
`define PIO_OFF_CTRL       8'h00
`define PIO_OFF_STATUS     8'h04
`define PIO_OFF_OUT_DATA   8'h08
`define PIO_OFF_OUT_EN     8'h0C
`define PIO_OFF_IN_DATA    8'h10
`define PIO_OFF_USED       8'h14
`define PIO_OFF_PULLUP     8'h18
`define PIO_OFF_IN_REG     8'h1C
`define PIO_OFF_OUT_REG    8'h20
`define PIO_CTRL_FREEZE    0
`define PIO_CTRL_CLK_EN    1
`define PIO_CTRL_CFG_START 2
`define PIO_CTRL_CFG_DONE  3
`define PIO_STAT_STATE_LO  0
`define PIO_STAT_CORE_ON   2
`define PIO_STAT_USER      3
`define PIO_CTRL_RESET     32'h0000_0002
`define PIO_CLK_NS         50
`define PIO_LOAD_NS        500
`define PIO_LOAD_CYCLES    ((`PIO_LOAD_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`endif

// >>> logic/pio_pkg.sv
// Types shared by the programmable I/O cell bank.
`default_nettype none
package pio_pkg;
  typedef enum logic [1:0] {
    PIO_ST_POR  = 2'b00,
    PIO_ST_LOAD = 2'b01,
    PIO_ST_USER = 2'b10
  } pio_state_e;
  typedef struct packed {
    logic freeze;
    logic clk_en;
  } pio_ctrl_s;
endpackage : pio_pkg
`default_nettype wire

// >>> logic/pio_bank.sv
// One bank of programmable I/O cells behind an AHB-Lite register slave.
`include "pio_consts.svh"
`default_nettype none
module pio_bank
  import pio_pkg::*;
#(
  parameter int NPADS = 8
)(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [7:0]       haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // Pads
  input  wire logic [NPADS-1:0] pad_in,
  output logic [NPADS-1:0]      pad_out,
  output logic [NPADS-1:0]      pad_oe,
  output logic [NPADS-1:0]      pad_pullup
);
  logic [NPADS-1:0] sync1_r, sync2_r;
  logic [NPADS-1:0] out_data_r, out_data_nxt, out_en_r, out_en_nxt;
  logic [NPADS-1:0] used_r, used_nxt, pull_r, pull_nxt, inreg_r, inreg_nxt;
  logic [NPADS-1:0] outreg_r, outreg_nxt;
  logic [NPADS-1:0] in_q_r, in_q_nxt, hold_r, hold_nxt, oq_r, oq_nxt, oeq_r, oeq_nxt;
  logic [NPADS-1:0] to_core, drv_data, drv_en, in_sel;
  pio_ctrl_s        ctrl_r, ctrl_nxt;
  pio_state_e       st_r, st_nxt;
  logic [7:0]       cnt_r, cnt_nxt;
  logic             core_on_r, core_on_nxt;
  logic             ph_wr_r, ph_wr_nxt;
  logic [7:0]       ph_addr_r, ph_addr_nxt;
  logic [31:0]      rdata_r, rdata_nxt;
  logic             cfg_start, cfg_done, wr_ctrl;
  logic             user_mode;
  // The control reset word is split into its fields, since the struct packs them differently.
  localparam logic [31:0] CTRL_RST = `PIO_CTRL_RESET;

  // Pads are asynchronous to hclk, so each passes two flops first.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
    end
  end

  assign user_mode = (st_r == PIO_ST_USER);
  assign wr_ctrl   = ph_wr_r && (ph_addr_r == `PIO_OFF_CTRL);
  assign cfg_start = wr_ctrl && hwdata[`PIO_CTRL_CFG_START];
  assign cfg_done  = wr_ctrl && hwdata[`PIO_CTRL_CFG_DONE];

  // Configuration sequencer.
  always_comb
  begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    // Core logic wakes one edge after reset, and the load starts one edge later.
    core_on_nxt = 1'b1;
    unique case (st_r)
      PIO_ST_POR:
      begin
        if (core_on_r)
        begin
          st_nxt  = PIO_ST_LOAD;
          cnt_nxt = 8'(`PIO_LOAD_CYCLES);
        end
      end
      PIO_ST_LOAD:
      begin
        if (cnt_r != 8'h00)
          cnt_nxt = cnt_r - 8'h01;
        // A done mark before the load time has run is a partial download.
        if (cnt_r == 8'h00 && cfg_done)
          st_nxt = PIO_ST_USER;
      end
      PIO_ST_USER:
      begin
        if (cfg_start)
        begin
          st_nxt  = PIO_ST_LOAD;
          cnt_nxt = 8'(`PIO_LOAD_CYCLES);
        end
      end
      default:
        st_nxt = PIO_ST_POR;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r      <= PIO_ST_POR;
      cnt_r     <= 8'h00;
      core_on_r <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      core_on_r <= core_on_nxt;
    end
  end

  // Cell datapath: input, output and tri-state register paths.
  always_comb
  begin
    in_q_nxt = in_q_r;
    hold_nxt = hold_r;
    oq_nxt   = oq_r;
    oeq_nxt  = oeq_r;
    if (ctrl_r.clk_en && core_on_r)
    begin
      in_q_nxt = sync2_r;
      oq_nxt   = out_data_r;
      oeq_nxt  = out_en_r;
    end
    if (!ctrl_r.freeze)
      hold_nxt = sync2_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in_q_r <= '0;
      hold_r <= '0;
      oq_r   <= '0;
      oeq_r  <= '0;
    end
    else
    begin
      in_q_r <= in_q_nxt;
      hold_r <= hold_nxt;
      oq_r   <= oq_nxt;
      oeq_r  <= oeq_nxt;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NPADS; i++)
    begin
      // A registered input ignores the freeze; only its clock enable holds it.
      if (inreg_r[i])
        in_sel[i] = in_q_r[i];
      else if (ctrl_r.freeze)
        in_sel[i] = hold_r[i];
      else
        in_sel[i] = sync2_r[i];
      to_core[i]  = in_sel[i] & used_r[i] & user_mode;
      drv_data[i] = outreg_r[i] ? oq_r[i] : out_data_r[i];
      drv_en[i]   = outreg_r[i] ? oeq_r[i] : out_en_r[i];
    end
  end

  // Outside user mode every pad floats with its pull-up on.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pad_out    <= '0;
      pad_oe     <= '0;
      pad_pullup <= '1;
    end
    else
    begin
      pad_out    <= drv_data;
      pad_oe     <= user_mode ? (drv_en & used_r) : '0;
      pad_pullup <= user_mode ? (pull_r & used_r) : '1;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY, unmapped reads give zero.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb
  begin
    ph_wr_nxt    = 1'b0;
    ph_addr_nxt  = ph_addr_r;
    ctrl_nxt     = ctrl_r;
    out_data_nxt = out_data_r;
    out_en_nxt   = out_en_r;
    used_nxt     = used_r;
    pull_nxt     = pull_r;
    inreg_nxt    = inreg_r;
    outreg_nxt   = outreg_r;
    rdata_nxt    = rdata_r;
    if (hsel && hready && htrans[1])
    begin
      ph_wr_nxt   = hwrite;
      ph_addr_nxt = haddr;
    end
    if (ph_wr_r)
    begin
      unique case (ph_addr_r)
        `PIO_OFF_CTRL:
        begin
          ctrl_nxt.freeze = hwdata[`PIO_CTRL_FREEZE];
          ctrl_nxt.clk_en = hwdata[`PIO_CTRL_CLK_EN];
        end
        `PIO_OFF_OUT_DATA: out_data_nxt = hwdata[NPADS-1:0];
        `PIO_OFF_OUT_EN:   out_en_nxt   = hwdata[NPADS-1:0];
        `PIO_OFF_USED:     used_nxt     = hwdata[NPADS-1:0];
        `PIO_OFF_PULLUP:   pull_nxt     = hwdata[NPADS-1:0];
        `PIO_OFF_IN_REG:   inreg_nxt    = hwdata[NPADS-1:0];
        `PIO_OFF_OUT_REG:  outreg_nxt   = hwdata[NPADS-1:0];
        default:           ;
      endcase
    end
    // Read data is built at the address phase so that it stands through the data phase.
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      rdata_nxt = 32'h0000_0000;
      unique case (haddr)
        `PIO_OFF_CTRL:     rdata_nxt[1:0] = {ctrl_r.clk_en, ctrl_r.freeze};
        `PIO_OFF_STATUS:
        begin
          rdata_nxt[`PIO_STAT_STATE_LO +: 2] = st_r;
          rdata_nxt[`PIO_STAT_CORE_ON]       = core_on_r;
          rdata_nxt[`PIO_STAT_USER]          = user_mode;
        end
        `PIO_OFF_OUT_DATA: rdata_nxt[NPADS-1:0] = out_data_r;
        `PIO_OFF_OUT_EN:   rdata_nxt[NPADS-1:0] = out_en_r;
        `PIO_OFF_IN_DATA:  rdata_nxt[NPADS-1:0] = to_core;
        `PIO_OFF_USED:     rdata_nxt[NPADS-1:0] = used_r;
        `PIO_OFF_PULLUP:   rdata_nxt[NPADS-1:0] = pull_r;
        `PIO_OFF_IN_REG:   rdata_nxt[NPADS-1:0] = inreg_r;
        `PIO_OFF_OUT_REG:  rdata_nxt[NPADS-1:0] = outreg_r;
        default:           ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_r    <= 1'b0;
      ph_addr_r  <= 8'h00;
      ctrl_r.freeze <= CTRL_RST[`PIO_CTRL_FREEZE];
      ctrl_r.clk_en <= CTRL_RST[`PIO_CTRL_CLK_EN];
      out_data_r <= '0;
      out_en_r   <= '0;
      used_r     <= '0;
      pull_r     <= '1;
      inreg_r    <= '0;
      outreg_r   <= '0;
      rdata_r    <= 32'h0000_0000;
    end
    else
    begin
      ph_wr_r    <= ph_wr_nxt;
      ph_addr_r  <= ph_addr_nxt;
      ctrl_r     <= ctrl_nxt;
      out_data_r <= out_data_nxt;
      out_en_r   <= out_en_nxt;
      used_r     <= used_nxt;
      pull_r     <= pull_nxt;
      inreg_r    <= inreg_nxt;
      outreg_r   <= outreg_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;

endmodule : pio_bank
`default_nettype wire

// >>> test/pio_bank_chk.sv
// Checker for the pad and bus behaviour of the I/O cell bank.
`include "pio_consts.svh"
`default_nettype none
module pio_bank_chk
#(
  parameter int NPADS = 8
)(
  // Clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // Bus
  input wire logic             hsel,
  input wire logic [7:0]       haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  // Pads
  input wire logic [NPADS-1:0] pad_in,
  input wire logic [NPADS-1:0] pad_out,
  input wire logic [NPADS-1:0] pad_oe,
  input wire logic [NPADS-1:0] pad_pullup
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       aph;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] wr_r, wr_nxt;
  assign aph = hsel && hready && htrans[1];
  // A write reaches the pads at most three edges after its address phase (registered path).
  always_comb
  begin
    cnt_nxt = (cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1;
    wr_nxt  = {wr_r[2:0], aph && hwrite};
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= 4'h0;
      wr_r  <= 4'h0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      wr_r  <= wr_nxt;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence cfg_start_wr;
    aph && hwrite && haddr == `PIO_OFF_CTRL ##1 hwdata[`PIO_CTRL_CFG_START];
  endsequence
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  por_float_a: assert property (cnt_r < 4'hC |-> pad_oe == '0)
    else $error("pad driven before configuration");
  por_pull_a: assert property (cnt_r < 4'hC |-> pad_pullup == '1)
    else $error("pull-up off before configuration");
  unmapped_zero_a: assert property (aph && !hwrite && haddr == 8'hFC |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(aph && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  reload_float_a: assert property (cfg_start_wr |-> ##2 (pad_oe == '0) [*7])
    else $error("pad driven during reload");
  reload_pull_a: assert property (cfg_start_wr |-> ##2 (pad_pullup == '1) [*7])
    else $error("pull-up off during reload");
  pads_quiet_a: assert property (wr_r == 4'h0 |->
    $stable(pad_oe) && $stable(pad_pullup) && $stable(pad_out))
    else $error("pad outputs moved without a write");
  cover property (cfg_start_wr);
  cover property (pad_oe != '0);
  cover property (aph && !hwrite && haddr == 8'hFC);
endmodule : pio_bank_chk
bind pio_bank pio_bank_chk #(.NPADS(NPADS)) i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup));
`default_nettype wire

// >>> test/pio_pads_model.sv
// Board model of the pads: drivers, pull-ups and external sources.
`default_nettype none
module pio_pads_model
#(
  parameter int NPADS = 8
)(
  // Clock
  input wire logic              hclk,
  // Cell side
  input wire logic [NPADS-1:0]  pad_out,
  input wire logic [NPADS-1:0]  pad_oe,
  input wire logic [NPADS-1:0]  pad_pullup,
  // External side
  input wire logic [NPADS-1:0]  ext_drv,
  input wire logic [NPADS-1:0]  ext_val,
  output logic [NPADS-1:0]      pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pad toggles so that a stale value can never pass for a real one.
  logic flt_r = 1'b0;
  always_ff @(posedge hclk) flt_r <= ~flt_r;
  always_comb
  begin
    for (int i = 0; i < NPADS; i++)
    begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_drv[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup[i]) pad_in[i] = 1'b1;
      else pad_in[i] = flt_r ^ i[0];
    end
  end
endmodule : pio_pads_model
`default_nettype wire

// >>> test/pio_bank_tb.sv
// Self-checking bench of the I/O cell bank over its register bus.
`include "pio_consts.svh"
`default_nettype none
module pio_bank_tb;
  import pio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00, ext_drv = 8'h00, ext_val = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic        hreadyout, hresp;
  logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup;
  int          mismatches = 0, n_tests = 0;
  always #25 hclk = ~hclk;
  pio_bank #(.NPADS(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup));
  pio_pads_model #(.NPADS(8)) i_pads (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in));
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(nm, hrdata, exp);
  endtask : rd_chk
  task automatic pads_chk(input logic [7:0] oe, input logic [7:0] pu, input logic [7:0] po);
    repeat (4) @(negedge hclk);
    check("pad_oe", {24'h0, pad_oe}, {24'h0, oe});
    check("pad_pullup", {24'h0, pad_pullup}, {24'h0, pu});
    check("pad_out", {24'h0, pad_out & pad_oe}, {24'h0, po});
  endtask : pads_chk
  initial
  begin
    repeat (3000) @(posedge hclk);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    pads_chk(8'h00, 8'hFF, 8'h00);
    rd_chk("status", `PIO_OFF_STATUS, 32'h5);
    // Completion written while loading is still counting must be ignored.
    bus(`PIO_OFF_CTRL, 1'b1, 32'hA);
    repeat (12) @(posedge hclk);
    rd_chk("status", `PIO_OFF_STATUS, 32'h5);
    rd_chk("ctrl", `PIO_OFF_CTRL, `PIO_CTRL_RESET);
    rd_chk("used", `PIO_OFF_USED, 32'h0);
    rd_chk("pullup", `PIO_OFF_PULLUP, 32'hFF);
    bus(`PIO_OFF_USED, 1'b1, 32'h0F);
    bus(`PIO_OFF_OUT_EN, 1'b1, 32'h05);
    bus(`PIO_OFF_OUT_DATA, 1'b1, 32'h03);
    bus(`PIO_OFF_PULLUP, 1'b1, 32'h3C);
    ext_drv <= 8'h0A;
    ext_val <= 8'h0A;
    pads_chk(8'h00, 8'hFF, 8'h00);
    rd_chk("in_data", `PIO_OFF_IN_DATA, 32'h0);
    bus(`PIO_OFF_CTRL, 1'b1, 32'hA);
    rd_chk("status", `PIO_OFF_STATUS, 32'hE);
    pads_chk(8'h05, 8'h0C, 8'h01);
    rd_chk("in_data", `PIO_OFF_IN_DATA, 32'h0B);
    bus(`PIO_OFF_IN_REG, 1'b1, 32'h08);
    bus(`PIO_OFF_OUT_REG, 1'b1, 32'h01);
    bus(`PIO_OFF_CTRL, 1'b1, 32'h3);
    ext_val <= 8'h00;
    repeat (3) @(posedge hclk);
    rd_chk("in_data", `PIO_OFF_IN_DATA, 32'h03);
    bus(`PIO_OFF_CTRL, 1'b1, 32'h1);
    ext_val <= 8'h08;
    bus(`PIO_OFF_OUT_DATA, 1'b1, 32'h02);
    pads_chk(8'h05, 8'h0C, 8'h01);
    rd_chk("in_data", `PIO_OFF_IN_DATA, 32'h03);
    bus(`PIO_OFF_CTRL, 1'b1, 32'h2);
    pads_chk(8'h05, 8'h0C, 8'h00);
    rd_chk("in_data", `PIO_OFF_IN_DATA, 32'h08);
    bus(8'hFC, 1'b1, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'hFC, 32'h0);
    bus(`PIO_OFF_CTRL, 1'b1, 32'h6);
    pads_chk(8'h00, 8'hFF, 8'h00);
    rd_chk("status", `PIO_OFF_STATUS, 32'h5);
    hresetn <= 1'b0;
    pads_chk(8'h00, 8'hFF, 8'h00);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("pullup", `PIO_OFF_PULLUP, 32'hFF);
    print_verdict();
  end
endmodule : pio_bank_tb
`default_nettype wire
